/* hw/pin_sync.v */
`timescale 1ns/1ns
`include "pwr_seq_defs.vh"

module pin_sync (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Pin in, clean level out
  input  wire pin_i,
  output reg  level_o
);

  reg [`SYNC_STAGES-1:0] stage_r;

  // Only stages two and three are compared; stage one feeds stage two alone
  always @(posedge clk_i) begin
    if (rst_i) begin
      stage_r <= {`SYNC_STAGES{1'b0}};
      level_o <= 1'b0;
    end else begin
      stage_r <= {stage_r[`SYNC_STAGES-2:0], pin_i};
      if (stage_r[`SYNC_STAGES-2] == stage_r[`SYNC_STAGES-1]) begin
        level_o <= stage_r[`SYNC_STAGES-1];
      end
    end
  end

endmodule // pin_sync

/* hw/power_mode_sequencer.v */
`timescale 1ns/1ns
`include "pwr_seq_defs.vh"

module power_mode_sequencer (
  // Clock and reset
  input  wire                  CLK_SYS_I,
  input  wire                  RESET_I,
  // Mode requests, one-cycle pulses from software
  input  wire                  REQ_FULL_ON_I,
  input  wire                  REQ_ACTIVE_I,
  input  wire                  REQ_SLEEP_I,
  input  wire                  REQ_DEEP_SLEEP_I,
  // PLL control register bits
  input  wire                  PLL_BYPASS_I,
  input  wire                  PLL_DISABLE_I,
  input  wire [`MULT_W-1:0]    PLL_MULT_I,
  input  wire                  PLL_MULT_WR_I,
  // Regulator control register frequency field
  input  wire [`REGULATOR_FREQUENCY_FIELD_W-1:0]    REG_REGULATOR_FREQUENCY_FIELD_I,
  input  wire                  REG_REGULATOR_FREQUENCY_FIELD_WR_I,
  // Peripheral clock enables
  input  wire [`PERIPH_N-1:0]  PERIPH_CLK_REQ_I,
  // External pins, asynchronous
  input  wire                  WAKEUP_PIN_I,
  input  wire                  RESET_PIN_N_I,
  // Mode and PLL
  output reg  [`MODE_W-1:0]    MODE_O,
  output reg                   PLL_EN_O,
  output reg                   PLL_BYPASS_O,
  output reg  [`MULT_W-1:0]    PLL_MULT_O,
  // Clock enables
  output reg                   CORE_CLK_EN_O,
  output reg                   SYS_CLK_EN_O,
  output reg  [`PERIPH_N-1:0]  PERIPH_CLK_EN_O,
  // Access permissions
  output reg                   DMA_L1L2_ALLOW_O,
  output reg                   DMA_EXT_ALLOW_O,
  output reg                   ASYNC_ACCESS_ALLOW_O,
  // Supply and pins
  output reg                   CORE_POWER_O,
  output reg                   PIN_HIZ_O,
  output reg                   RESTART_O
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire wakeup_lvl;
  wire rst_pin_n_lvl;
  reg  rst_pin_n_d_r;
  wire rst_pin_evt;

  pin_sync u_wake_sync (
    .clk_i   (CLK_SYS_I),
    .rst_i   (RESET_I),
    .pin_i   (WAKEUP_PIN_I),
    .level_o (wakeup_lvl)
  );

  pin_sync u_rstpin_sync (
    .clk_i   (CLK_SYS_I),
    .rst_i   (RESET_I),
    .pin_i   (RESET_PIN_N_I),
    .level_o (rst_pin_n_lvl)
  );

  // Falling edge of the clean reset pin level is the reset interrupt
  assign rst_pin_evt = rst_pin_n_d_r & ~rst_pin_n_lvl;

  // ****************************************
  // Mode state machine
  // ****************************************
  reg [`MODE_W-1:0] mode_r;
  reg [`MODE_W-1:0] mode_nxt;
  reg               boot_r;
  reg               restart_nxt;
  wire [`MODE_W-1:0] resume_mode;
  wire               pll_off_act;

  // Bypass bit decides where a restart or wakeup lands
  assign resume_mode = PLL_BYPASS_I ? `MODE_ACTIVE : `MODE_FULL_ON;  // [R15]
  // PLL shutdown honoured only in active mode
  assign pll_off_act = (mode_r == `MODE_ACTIVE) & PLL_DISABLE_I;      // [R07]

  always @* begin
    mode_nxt    = mode_r;
    restart_nxt = 1'b0;
    if (rst_pin_evt) begin
      // Reset pin wakes the regulator and restarts from any mode
      mode_nxt    = resume_mode;                                     // [R18] [R14]
      restart_nxt = 1'b1;                                            // [R18]
    end else if (boot_r) begin
      mode_nxt = resume_mode;                                        // [R20]
    end else if (REG_REGULATOR_FREQUENCY_FIELD_WR_I && REG_REGULATOR_FREQUENCY_FIELD_I == `REGULATOR_FREQUENCY_FIELD_OFF &&
                 mode_r != `MODE_HIBERNATE &&
                 mode_r != `MODE_DEEP_SLEEP) begin
      // Deep sleep ends on the reset pin alone, so no write may leave it
      mode_nxt = `MODE_HIBERNATE;                                    // [R16] [R14]
    end else begin
      case (mode_r)
        `MODE_FULL_ON: begin
          if (REQ_DEEP_SLEEP_I) begin
            mode_nxt = `MODE_DEEP_SLEEP;
          end else if (REQ_SLEEP_I) begin
            mode_nxt = `MODE_SLEEP;
          end else if (REQ_ACTIVE_I) begin
            mode_nxt = `MODE_ACTIVE;
          end
        end
        `MODE_ACTIVE: begin
          // Defensive: a sleep or full-on request against a stopped PLL is held off
          if (REQ_DEEP_SLEEP_I) begin
            mode_nxt = `MODE_DEEP_SLEEP;
          end else if (REQ_SLEEP_I && !PLL_DISABLE_I) begin
            mode_nxt = `MODE_SLEEP;                                  // [R08]
          end else if (REQ_FULL_ON_I && !PLL_DISABLE_I) begin
            mode_nxt = `MODE_FULL_ON;                                // [R08]
          end
        end
        `MODE_SLEEP: begin
          if (wakeup_lvl) begin
            mode_nxt = resume_mode;                                  // [R10]
          end
        end
        `MODE_DEEP_SLEEP: begin
          mode_nxt = mode_r;                                         // [R14]
        end
        `MODE_HIBERNATE: begin
          mode_nxt = mode_r;                                         // [R18]
        end
        default: begin
          mode_nxt = `MODE_FULL_ON;
        end
      endcase
    end
  end

  // ****************************************
  // Per-mode settings
  // ****************************************
  reg core_tgt;
  reg sys_tgt;

  always @* begin
    core_tgt = 1'b0;
    sys_tgt  = 1'b0;
    case (mode_nxt)
      `MODE_FULL_ON: begin
        core_tgt = 1'b1;                                             // [R03]
        sys_tgt  = 1'b1;
      end
      `MODE_ACTIVE: begin
        core_tgt = 1'b1;                                             // [R04]
        sys_tgt  = 1'b1;
      end
      `MODE_SLEEP: begin
        sys_tgt  = 1'b1;                                             // [R09]
      end
      `MODE_DEEP_SLEEP: begin
        sys_tgt  = 1'b0;                                             // [R12]
      end
      `MODE_HIBERNATE: begin
        sys_tgt  = 1'b0;                                             // [R16]
      end
      default: begin
        sys_tgt  = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Multiplier staging
  // ****************************************
  reg [`MULT_W-1:0] mult_pend_r;
  reg [`MULT_W-1:0] mult_pend_nxt;

  always @* begin
    mult_pend_nxt = PLL_MULT_WR_I ? PLL_MULT_I : mult_pend_r;
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      mode_r               <= `MODE_FULL_ON;                         // [R03]
      boot_r               <= 1'b1;
      // Synced level restarts low; a high history here would fake a pin edge
      rst_pin_n_d_r        <= 1'b0;
      mult_pend_r          <= `MULT_RESET;
      MODE_O               <= `MODE_FULL_ON;
      PLL_EN_O             <= 1'b1;
      PLL_BYPASS_O         <= 1'b0;
      PLL_MULT_O           <= `MULT_RESET;
      CORE_CLK_EN_O        <= 1'b0;
      SYS_CLK_EN_O         <= 1'b0;
      DMA_L1L2_ALLOW_O     <= 1'b0;
      DMA_EXT_ALLOW_O      <= 1'b0;
      ASYNC_ACCESS_ALLOW_O <= 1'b0;
      CORE_POWER_O         <= 1'b1;
      PIN_HIZ_O            <= 1'b0;
      RESTART_O            <= 1'b0;
    end else begin
      mode_r        <= mode_nxt;                                     // [R01]
      boot_r        <= 1'b0;
      rst_pin_n_d_r <= rst_pin_n_lvl;
      mult_pend_r   <= mult_pend_nxt;
      MODE_O        <= mode_nxt;
      RESTART_O     <= restart_nxt;
      // New multiplier reaches the PLL only in full-on
      if (mode_nxt == `MODE_FULL_ON) begin
        PLL_MULT_O <= mult_pend_nxt;                                 // [R05]
      end
      PLL_EN_O <= (mode_nxt == `MODE_FULL_ON) | (mode_nxt == `MODE_SLEEP) |
                  ((mode_nxt == `MODE_ACTIVE) & ~pll_off_act);       // [R07]
      PLL_BYPASS_O <= (mode_nxt == `MODE_ACTIVE);                    // [R04]
      // Stop core before system; start system before core
      CORE_CLK_EN_O <= core_tgt & SYS_CLK_EN_O;                      // [R19]
      SYS_CLK_EN_O  <= sys_tgt | CORE_CLK_EN_O;                      // [R19]
      DMA_L1L2_ALLOW_O <= (mode_nxt == `MODE_FULL_ON) |
                          (mode_nxt == `MODE_ACTIVE);                // [R06] [R11]
      DMA_EXT_ALLOW_O  <= (mode_nxt == `MODE_FULL_ON) |
                          (mode_nxt == `MODE_ACTIVE) |
                          (mode_nxt == `MODE_SLEEP);                 // [R11]
      ASYNC_ACCESS_ALLOW_O <= (mode_nxt != `MODE_DEEP_SLEEP) &
                              (mode_nxt != `MODE_HIBERNATE);         // [R13]
      CORE_POWER_O <= (mode_nxt != `MODE_HIBERNATE);                 // [R16]
      PIN_HIZ_O    <= (mode_nxt == `MODE_HIBERNATE);                 // [R17]
    end
  end

  // ****************************************
  // Peripheral clock enables
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `PERIPH_N; gi = gi + 1) begin : g_periph
      // Follows the registered system enable, so stops one cycle after it
      always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
          PERIPH_CLK_EN_O[gi] <= 1'b0;
        end else begin
          PERIPH_CLK_EN_O[gi] <= PERIPH_CLK_REQ_I[gi] & SYS_CLK_EN_O; // [R02] [R19]
        end
      end
    end
  endgenerate

endmodule // power_mode_sequencer

/* hw/pwr_seq_defs.vh */
// Function
// R01 - Four modes plus hibernate, each with settings
// R02 - Each peripheral clock enabled on its own
// R03 - Full-on: PLL running, unbypassed; default state
// R04 - Active: PLL bypassed, clocks at input rate
// R05 - Multiplier written in active applies at full-on
// R06 - Active: DMA reaches level-one and level-two memory
// R07 - Active: PLL may be switched off
// R08 - Re-enable PLL before full-on or sleep request
// R09 - Sleep: core clock stopped, PLL and system run
// R10 - Sleep wakeup samples bypass bit for resume
// R11 - Sleep: DMA only to external memory
// R12 - Deep sleep: core and system clocks stopped
// R13 - Deep sleep: asynchronous peripherals denied access
// R14 - Deep sleep left only by reset interrupt
// R15 - Deep sleep exit: bypass picks active or full-on
// R16 - Frequency field 00 enters hibernate, supply off
// R17 - Hibernate: external pins high impedance
// R18 - Reset pin wakes regulator and restarts processor
// R19 - Clock gating free of glitches and runt pulses
// R20 - Hardware reset enters full-on unless bypass set
`ifndef PWR_SEQ_DEFS_VH
`define PWR_SEQ_DEFS_VH

// ****************************************
// Mode encoding, one-hot
// ****************************************
`define MODE_W          5
`define MODE_FULL_ON    5'h01
`define MODE_ACTIVE     5'h02
`define MODE_SLEEP      5'h04
`define MODE_DEEP_SLEEP 5'h08
`define MODE_HIBERNATE  5'h10

// ****************************************
// Widths and field values
// ****************************************
`define MULT_W          6
`define MULT_RESET      6'h0a
`define REGULATOR_FREQUENCY_FIELD_W          2
`define REGULATOR_FREQUENCY_FIELD_OFF        2'h0
`define PERIPH_N        8
`define SYNC_STAGES     3

`endif

/* testbench/power_mode_sequencer_assertions.sv */
`timescale 1ns/1ns
`include "pwr_seq_defs.vh"

module power_mode_sequencer_assertions (
  // Clock and reset
  input wire                 CLK_SYS_I,
  input wire                 RESET_I,
  // Watched inputs
  input wire                 REQ_SLEEP_I,
  input wire                 PLL_BYPASS_I,
  input wire [`REGULATOR_FREQUENCY_FIELD_W-1:0]   REG_REGULATOR_FREQUENCY_FIELD_I,
  input wire                 REG_REGULATOR_FREQUENCY_FIELD_WR_I,
  input wire                 RESET_PIN_N_I,
  // Watched outputs
  input wire [`MODE_W-1:0]   MODE_O,
  input wire                 PLL_EN_O,
  input wire                 PLL_BYPASS_O,
  input wire [`MULT_W-1:0]   PLL_MULT_O,
  input wire                 CORE_CLK_EN_O,
  input wire                 SYS_CLK_EN_O,
  input wire [`PERIPH_N-1:0] PERIPH_CLK_EN_O,
  input wire                 DMA_L1L2_ALLOW_O,
  input wire                 DMA_EXT_ALLOW_O,
  input wire                 ASYNC_ACCESS_ALLOW_O,
  input wire                 CORE_POWER_O,
  input wire                 PIN_HIZ_O,
  input wire                 RESTART_O
);
  // ****
  // Mode decode
  // ****
  wire m_on  = MODE_O == `MODE_FULL_ON;
  wire m_act = MODE_O == `MODE_ACTIVE;
  wire m_slp = MODE_O == `MODE_SLEEP;
  wire m_dp  = MODE_O == `MODE_DEEP_SLEEP;
  wire m_hib = MODE_O == `MODE_HIBERNATE;

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);

  full_on_pll_a: assert property (m_on |-> PLL_EN_O && !PLL_BYPASS_O)
    else $error("full-on PLL state wrong");
  active_bypass_a: assert property (m_act |-> PLL_BYPASS_O && DMA_L1L2_ALLOW_O)
    else $error("active mode bypass or DMA wrong");
  sleep_gate_a: assert property (m_slp |-> !CORE_CLK_EN_O && SYS_CLK_EN_O && PLL_EN_O
    && !DMA_L1L2_ALLOW_O && DMA_EXT_ALLOW_O) else $error("sleep gating wrong");
  sleep_entry_a: assert property (REQ_SLEEP_I && m_on && !REG_REGULATOR_FREQUENCY_FIELD_WR_I |=> m_slp)
    else $error("sleep request not taken");
  deep_stop_a: assert property ($rose(m_dp) |-> !CORE_CLK_EN_O && SYS_CLK_EN_O
    && !ASYNC_ACCESS_ALLOW_O ##1 !SYS_CLK_EN_O ##1 PERIPH_CLK_EN_O == 0)
    else $error("deep sleep stop order wrong");
  deep_exit_a: assert property ($fell(m_dp) |-> !RESET_PIN_N_I
    && MODE_O == (PLL_BYPASS_I ? `MODE_ACTIVE : `MODE_FULL_ON)) else $error("bad deep exit");
  hib_entry_a: assert property (REG_REGULATOR_FREQUENCY_FIELD_WR_I && REG_REGULATOR_FREQUENCY_FIELD_I == `REGULATOR_FREQUENCY_FIELD_OFF && (m_on || m_act)
    |=> m_hib && !CORE_POWER_O && PIN_HIZ_O) else $error("hibernate entry wrong");
  restart_pulse_a: assert property (RESTART_O |-> !RESET_PIN_N_I ##1 !RESTART_O)
    else $error("restart pulse wrong");
  clock_start_a: assert property ($rose(SYS_CLK_EN_O) |-> !CORE_CLK_EN_O ##1 CORE_CLK_EN_O)
    else $error("clock start order wrong");
  mult_hold_a: assert property (!m_on && RESET_PIN_N_I |-> $stable(PLL_MULT_O))
    else $error("multiplier changed outside full-on");
  boot_mode_a: assert property ($fell(RESET_I) |=> MODE_O ==
    ($past(PLL_BYPASS_I) ? `MODE_ACTIVE : `MODE_FULL_ON)) else $error("bad mode after reset");
endmodule // power_mode_sequencer_assertions

bind power_mode_sequencer power_mode_sequencer_assertions chk_i (
  .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .REQ_SLEEP_I(REQ_SLEEP_I),
  .PLL_BYPASS_I(PLL_BYPASS_I), .REG_REGULATOR_FREQUENCY_FIELD_I(REG_REGULATOR_FREQUENCY_FIELD_I), .REG_REGULATOR_FREQUENCY_FIELD_WR_I(REG_REGULATOR_FREQUENCY_FIELD_WR_I),
  .RESET_PIN_N_I(RESET_PIN_N_I), .MODE_O(MODE_O), .PLL_EN_O(PLL_EN_O),
  .PLL_BYPASS_O(PLL_BYPASS_O), .PLL_MULT_O(PLL_MULT_O), .CORE_CLK_EN_O(CORE_CLK_EN_O),
  .SYS_CLK_EN_O(SYS_CLK_EN_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
  .DMA_L1L2_ALLOW_O(DMA_L1L2_ALLOW_O), .DMA_EXT_ALLOW_O(DMA_EXT_ALLOW_O),
  .ASYNC_ACCESS_ALLOW_O(ASYNC_ACCESS_ALLOW_O), .CORE_POWER_O(CORE_POWER_O),
  .PIN_HIZ_O(PIN_HIZ_O), .RESTART_O(RESTART_O));

/* testbench/power_mode_sequencer_tb_top.sv */
`timescale 1ns/1ns
`include "pwr_seq_defs.vh"

module power_mode_sequencer_tb_top;
  // ****
  // Stimulus and observation
  // ****
  reg                  clk = 1'b0;
  reg                  rst = 1'b1;
  reg  [3:0]           rq = 4'h0;
  reg                  byp = 1'b0, pdis = 1'b0, mwr = 1'b0, fwr = 1'b0, wake = 1'b0;
  reg                  rpin_n = 1'b1;
  reg  [`MULT_W-1:0]   mult = 6'h00, m1, m2;
  reg  [`REGULATOR_FREQUENCY_FIELD_W-1:0]   regulator_frequency_field = 2'h3;
  reg  [`PERIPH_N-1:0] preq = 8'h00;
  reg  [31:0]          rnd;
  wire [`MODE_W-1:0]   mode;
  wire [`MULT_W-1:0]   mult_o;
  wire [`PERIPH_N-1:0] per_en;
  wire                 pll_en, pll_byp, core_en, sys_en, dma_l, dma_e, async_ok, pwr, hiz, restart;
  integer              seed = 32'hf886, n_mismatch = 0, num_checks = 0, nrst = 0, cyc = 0, b;

  power_mode_sequencer dut (
    .CLK_SYS_I(clk), .RESET_I(rst), .REQ_FULL_ON_I(rq[0]), .REQ_ACTIVE_I(rq[1]),
    .REQ_SLEEP_I(rq[2]), .REQ_DEEP_SLEEP_I(rq[3]), .PLL_BYPASS_I(byp), .PLL_DISABLE_I(pdis),
    .PLL_MULT_I(mult), .PLL_MULT_WR_I(mwr), .REG_REGULATOR_FREQUENCY_FIELD_I(regulator_frequency_field), .REG_REGULATOR_FREQUENCY_FIELD_WR_I(fwr),
    .PERIPH_CLK_REQ_I(preq), .WAKEUP_PIN_I(wake), .RESET_PIN_N_I(rpin_n), .MODE_O(mode),
    .PLL_EN_O(pll_en), .PLL_BYPASS_O(pll_byp), .PLL_MULT_O(mult_o), .CORE_CLK_EN_O(core_en),
    .SYS_CLK_EN_O(sys_en), .PERIPH_CLK_EN_O(per_en), .DMA_L1L2_ALLOW_O(dma_l),
    .DMA_EXT_ALLOW_O(dma_e), .ASYNC_ACCESS_ALLOW_O(async_ok), .CORE_POWER_O(pwr),
    .PIN_HIZ_O(hiz), .RESTART_O(restart));

  initial begin
    forever #2 clk = ~clk;
  end

  // Counts restarts so a doubled pulse shows up
  always @(posedge clk) begin
    if (restart === 1'b1) nrst <= nrst + 1;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end

  // ****
  // Helpers
  // ****
  function [`MODE_W-1:0] resume(input bp);
    resume = bp ? `MODE_ACTIVE : `MODE_FULL_ON;
  endfunction

  task w(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task pulse(input [3:0] k);
    begin
      @(posedge clk);
      rq <= k;
      @(posedge clk);
      rq <= 4'h0;
      w(1);
    end
  endtask

  // Register write strobe: regulator field when f is set, else multiplier
  task wr(input f, input [5:0] v);
    begin
      @(posedge clk);
      if (f) regulator_frequency_field <= v[1:0];
      else mult <= v;
      fwr <= f;
      mwr <= !f;
      @(posedge clk);
      fwr <= 1'b0;
      mwr <= 1'b0;
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    rnd = $random(seed);
    preq = rnd[`PERIPH_N-1:0];
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    w(3);
    chk(mode, `MODE_FULL_ON);
    chk({pll_en, pll_byp, core_en, sys_en, pwr, hiz, mult_o}, {6'h2e, `MULT_RESET});
    chk(per_en, preq);
    rnd = $random(seed);
    m1 = rnd[`MULT_W-1:0];
    m2 = ~m1;
    wr(0, m1);
    w(2);
    chk(mult_o, m1);
    pulse(4'h2);
    chk({mode, pll_byp, dma_l}, {`MODE_ACTIVE, 2'h3});
    wr(0, m2);
    pdis <= 1'b1;
    w(2);
    chk({pll_en, mult_o}, {1'b0, m1});
    pulse(4'h4);
    pulse(4'h1);
    chk(mode, `MODE_ACTIVE);
    @(posedge clk);
    pdis <= 1'b0;
    rnd = $random(seed);
    preq <= rnd[`PERIPH_N-1:0];
    pulse(4'h1);
    chk({mode, mult_o, per_en}, {`MODE_FULL_ON, m2, preq});
    $display("test done: active");
    for (b = 0; b < 2; b = b + 1) begin
      @(posedge clk);
      byp <= b[0];
      pulse(4'h4);
      pulse(4'h2);
      chk({mode, core_en, sys_en, dma_l, dma_e}, {`MODE_SLEEP, 4'h5});
      @(posedge clk);
      wake <= 1'b1;
      w(8);
      chk(mode, resume(b[0]));
      @(posedge clk);
      wake <= 1'b0;
      w(6);
    end
    $display("test done: sleep");
    for (b = 0; b < 2; b = b + 1) begin
      pulse(4'h8);
      // Regulator-off write must not end deep sleep
      wr(1, {4'h0, `REGULATOR_FREQUENCY_FIELD_OFF});
      @(posedge clk);
      wake <= 1'b1;
      byp <= b[0];
      w(8);
      chk({mode, core_en, sys_en, per_en, async_ok}, {`MODE_DEEP_SLEEP, 11'h000});
      @(posedge clk);
      wake <= 1'b0;
      rpin_n <= 1'b0;
      w(10);
      chk(mode, resume(b[0]));
      @(posedge clk);
      rpin_n <= 1'b1;
      w(6);
    end
    chk(nrst, 2);
    $display("test done: deep sleep");
    wr(1, 6'h01);
    w(2);
    chk(mode, `MODE_ACTIVE);
    wr(1, {4'h0, `REGULATOR_FREQUENCY_FIELD_OFF});
    w(2);
    chk({mode, pwr, hiz}, {`MODE_HIBERNATE, 2'h1});
    @(posedge clk);
    rpin_n <= 1'b0;
    w(10);
    chk({mode, pwr, hiz, nrst[1:0]}, {`MODE_ACTIVE, 2'h2, 2'h3});
    @(posedge clk);
    rpin_n <= 1'b1;
    rst <= 1'b1;
    w(3);
    @(posedge clk);
    rst <= 1'b0;
    w(3);
    chk(mode, `MODE_ACTIVE);
    $display("test done: hibernate and reset");
    stop_test;
  end
endmodule // power_mode_sequencer_tb_top
